// *** hdl/sadc_pkg.sv ***
// shared constants for the subranging converter sample pipeline
package sadc_pkg;
  localparam int unsigned SADC_CLK_MHZ = 100;
  localparam int unsigned SADC_COARSE_W = 5;
  localparam int unsigned SADC_FINE_W = 6;
  localparam int unsigned SADC_WORD_W = 10;
  localparam int unsigned SADC_SEL_N = 32;
  localparam int unsigned SADC_FIFO_W = 11;
  localparam int unsigned SADC_FIFO_D = 8;
  localparam logic [9:0] SADC_WORD_RST = 10'h200;
  localparam logic [4:0] SADC_COARSE_MAX = 5'h1f;
  localparam logic [31:0] SADC_SEL_RST = 32'h0000_0000;
  localparam logic [10:0] SADC_FIFO_RST = 11'h200;
  localparam int unsigned SADC_LAT_HALF = 5;
  localparam logic [1:0] SADC_STAGES_BEFORE_OUT = 2'h2;

  typedef enum logic [2:0] {
    SADC_ST_IDLE = 3'b001,
    SADC_ST_FILL = 3'b010,
    SADC_ST_RUN = 3'b100
  } sadc_state_t;

  // combine coarse and fine codes into the offset binary word, saturating
  function automatic logic [10:0] sadc_combine(input logic [4:0] coarse, input logic [5:0] fine);
    logic [5:0] top;
    top = {1'b0, coarse} + {5'h00, fine[5]};
    if (top[5]) begin
      return {1'b1, 10'h3ff};
    end
    return {1'b0, top[4:0], fine[4:0]};
  endfunction
endpackage

// *** hdl/sadc_stream_if.sv ***
// valid/ready stream carrying converted words
`timescale 1ns/1ps
`default_nettype none
interface sadc_stream_if #(parameter int unsigned W = 11);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** hdl/sadc_fifo.sv ***
// parameterised fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo #(
  parameter int unsigned W = 11,
  parameter int unsigned D = 8
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  sadc_stream_if.snk in_s, // filling side
  sadc_stream_if.src out_s // draining side
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  assign in_s.ready = (cnt_ff < (AW+1)'(D));
  assign out_s.valid = (cnt_ff != '0);
  assign out_s.data = mem_ff[rd_ff];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_s.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(D - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(D - 1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// *** hdl/sadc_pipeline.sv ***
// subranging converter digital pipeline: coarse/fine decode and latched output word
`timescale 1ns/1ps
`default_nettype none
module sadc_pipeline
  import sadc_pkg::*;
(
  input wire logic clk_i, // 100 MHz system clock
  input wire logic rst_i, // sync reset, active high
  input wire logic strobe_i, // sample strobe pin, asynchronous
  input wire logic [4:0] coarse_i, // coarse flash code, asynchronous
  input wire logic [5:0] fine_i, // fine flash code, asynchronous
  input wire logic over_i, // input beyond full scale comparator
  output logic [9:0] word_o, // latched result word, offset binary
  output logic range_o, // out-of-range flag
  output logic [31:0] ladder_sel_o, // one-hot residue ladder switch enable
  output logic word_valid_o, // word carries a real sample
  output logic busy_o // pipeline filling or running
);
  logic [2:0] strb_sync_ff;
  logic [4:0] coarse_s1_ff;
  logic [4:0] coarse_s2_ff;
  logic [5:0] fine_s1_ff;
  logic [5:0] fine_s2_ff;
  logic over_s1_ff;
  logic over_s2_ff;
  logic rise;
  logic fall;
  logic [4:0] coarse_held_ff;
  logic over_held_ff;
  logic [10:0] dec_word_ff;
  logic [1:0] fill_ff;
  logic [9:0] word_ff;
  logic range_ff;
  logic [31:0] sel_ff;
  logic valid_ff;
  logic busy_ff;
  sadc_state_t state_ff;
  sadc_state_t nxt_state;
  logic [10:0] comb;

  sadc_stream_if #(.W(SADC_FIFO_W)) fin_s ();
  sadc_stream_if #(.W(SADC_FIFO_W)) fout_s ();

  // pin inputs pass two flops; the third strobe stage only feeds edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strb_sync_ff <= 3'h0;
      coarse_s1_ff <= 5'h00;
      coarse_s2_ff <= 5'h00;
      fine_s1_ff <= 6'h00;
      fine_s2_ff <= 6'h00;
      over_s1_ff <= 1'b0;
      over_s2_ff <= 1'b0;
    end else begin
      strb_sync_ff <= {strb_sync_ff[1:0], strobe_i};
      coarse_s1_ff <= coarse_i;
      coarse_s2_ff <= coarse_s1_ff;
      fine_s1_ff <= fine_i;
      fine_s2_ff <= fine_s1_ff;
      over_s1_ff <= over_i;
      over_s2_ff <= over_s1_ff;
    end
  end

  assign rise = strb_sync_ff[1] && !strb_sync_ff[2];
  assign fall = !strb_sync_ff[1] && strb_sync_ff[2];

  // hold coarse result at the sampling edge, residue switch chosen from it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coarse_held_ff <= 5'h00;
      over_held_ff <= 1'b0;
      sel_ff <= SADC_SEL_RST;
    end else if (rise) begin
      coarse_held_ff <= coarse_s2_ff;
      over_held_ff <= over_s2_ff;
      sel_ff <= 32'h0000_0001 << coarse_s2_ff;
    end
  end

  // fine code arrives a period later; pair it with its own coarse code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_word_ff <= SADC_FIFO_RST;
    end else if (rise) begin
      // coarse held at the previous rise and the fine code present now belong to one sample
      dec_word_ff <= {over_held_ff | comb[10], comb[9:0]};
    end
  end

  assign comb = sadc_combine(coarse_held_ff, fine_s2_ff);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SADC_ST_IDLE: begin
        if (rise) begin
          nxt_state = SADC_ST_FILL;
        end
      end
      SADC_ST_FILL: begin
        if (rise && fill_ff == SADC_STAGES_BEFORE_OUT) begin
          nxt_state = SADC_ST_RUN;
        end
      end
      SADC_ST_RUN: nxt_state = SADC_ST_RUN;
      default: nxt_state = SADC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= SADC_ST_IDLE;
      fill_ff <= 2'h0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state != SADC_ST_IDLE);
      if (rise && fill_ff != SADC_STAGES_BEFORE_OUT) begin
        fill_ff <= fill_ff + 2'h1;
      end
    end
  end

  // decoded words queue until the next falling edge releases one
  // the first real word is decoded by the second rise and queued at the third
  assign fin_s.valid = rise && (fill_ff == SADC_STAGES_BEFORE_OUT);
  assign fin_s.data = dec_word_ff;
  assign fout_s.ready = fall;

  sadc_fifo #(.W(SADC_FIFO_W), .D(SADC_FIFO_D)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_s(fin_s),
    .out_s(fout_s)
  );

  // output word and flag change only on the falling edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_ff <= SADC_WORD_RST;
      range_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else if (fall && fout_s.valid) begin
      word_ff <= fout_s.data[9:0];
      range_ff <= fout_s.data[10];
      valid_ff <= 1'b1;
    end
  end

  assign word_o = word_ff;
  assign range_o = range_ff;
  assign ladder_sel_o = sel_ff;
  assign word_valid_o = valid_ff;
  assign busy_o = busy_ff;
endmodule
`default_nettype wire

// *** tb/sadc_props.sv ***
// port-level assertion checker for the sample pipeline
`timescale 1ns/1ps
`default_nettype none
module sadc_props (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic strobe_i, // strobe
  input wire logic [4:0] coarse_i, // coarse
  input wire logic [5:0] fine_i, // fine
  input wire logic over_i, // over
  input wire logic [9:0] word_o, // word
  input wire logic range_o, // range
  input wire logic [31:0] ladder_sel_o, // ladder
  input wire logic word_valid_o, // valid
  input wire logic busy_o // busy
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ladder_onehot: assert property (
    $changed(ladder_sel_o) |-> ladder_sel_o == 32'h1 << $past(coarse_i, 4)) else $error("ladder code wrong");
  chk_start_rise: assert property (
    $changed(ladder_sel_o) |-> $past(strobe_i, 3) && !$past(strobe_i, 5)) else $error("ladder off rise");
  chk_word_fall: assert property (
    $changed(word_o) |-> !$past(strobe_i, 3) && $past(strobe_i, 6)) else $error("word off fall");
  chk_range_fall: assert property (
    $changed(range_o) |-> !$past(strobe_i, 3) && $past(strobe_i, 6)) else $error("range off fall");
  chk_range_word: assert property (
    range_o |-> (word_o == 10'h3ff) || (word_o == 10'h000)) else $error("range without end of scale word");
  chk_valid_lat: assert property (
    $rose(word_valid_o) |-> $past(busy_o, 20) && !$past(busy_o, 30)) else $error("first word latency");
  chk_valid_busy: assert property (
    word_valid_o |-> busy_o) else $error("valid while idle");
  chk_valid_keep: assert property (
    !$fell(word_valid_o)) else $error("valid dropped");
endmodule
bind sadc_pipeline sadc_props chk_u (.clk_i(clk_i), .rst_i(rst_i), .strobe_i(strobe_i), .coarse_i(coarse_i),
  .fine_i(fine_i), .over_i(over_i), .word_o(word_o), .range_o(range_o), .ladder_sel_o(ladder_sel_o),
  .word_valid_o(word_valid_o), .busy_o(busy_o));
`default_nettype wire

// *** tb/sadc_capture.sv ***
// capture side model: free-running strobe and word capture
`timescale 1ns/1ps
`default_nettype none
module sadc_capture (
  input wire logic clk_i, // clock
  input wire logic run_i, // strobe enable
  input wire logic [9:0] word_i, // word
  input wire logic range_i, // range
  input wire logic valid_i, // valid
  output logic strobe_o, // strobe
  output logic [9:0] cap_word_o, // captured word
  output logic cap_range_o, // captured range
  output logic cap_valid_o // captured valid
);
  logic [3:0] cnt_ff = 4'h0;
  logic strobe_ff = 1'b0;
  // five clocks high, five low: 10 MSPS, even duty, unbroken while running
  always @(negedge clk_i) begin
    cnt_ff <= (!run_i || cnt_ff == 4'h9) ? 4'h0 : cnt_ff + 4'h1;
    strobe_ff <= run_i && cnt_ff < 4'h5;
  end
  assign strobe_o = strobe_ff;
  // latch on the rise after each output fall
  always @(posedge strobe_o) begin
    cap_word_o <= word_i;
    cap_range_o <= range_i;
    cap_valid_o <= valid_i;
  end
endmodule
`default_nettype wire

// *** tb/test_sadc_pipeline.sv ***
// self-checking bench for the sample pipeline
`timescale 1ns/1ps
`default_nettype none
module test_sadc_pipeline;
  typedef struct {logic [4:0] c; logic [5:0] f; logic o; logic [9:0] w; logic r;} sadc_row_t;
  sadc_row_t rows [8] = '{'{5'h00, 6'h00, 1'h0, 10'h000, 1'h0}, '{5'h1f, 6'h1f, 1'h0, 10'h3ff, 1'h0},
    '{5'h1f, 6'h20, 1'h0, 10'h3ff, 1'h1}, '{5'h10, 6'h00, 1'h0, 10'h200, 1'h0},
    '{5'h0f, 6'h3f, 1'h0, 10'h21f, 1'h0}, '{5'h00, 6'h00, 1'h1, 10'h000, 1'h1},
    '{5'h1e, 6'h25, 1'h0, 10'h3e5, 1'h0}, '{5'h00, 6'h20, 1'h0, 10'h020, 1'h0}};
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic run = 1'h0;
  logic over_i = 1'h0;
  logic [4:0] coarse_i = 5'h00;
  logic [5:0] fine_i = 6'h00;
  logic strobe, range_o, word_valid_o, busy_o, cap_range, cap_valid;
  logic [9:0] word_o, cap_word;
  logic [31:0] ladder_sel_o;
  int errors = 0;
  int total_checks = 0;
  always #5 clk_i = ~clk_i;
  sadc_pipeline dut_u (.clk_i(clk_i), .rst_i(rst_i), .strobe_i(strobe), .coarse_i(coarse_i), .fine_i(fine_i),
    .over_i(over_i), .word_o(word_o), .range_o(range_o), .ladder_sel_o(ladder_sel_o),
    .word_valid_o(word_valid_o), .busy_o(busy_o));
  sadc_capture far_u (.clk_i(clk_i), .run_i(run), .word_i(word_o), .range_i(range_o), .valid_i(word_valid_o),
    .strobe_o(strobe), .cap_word_o(cap_word), .cap_range_o(cap_range), .cap_valid_o(cap_valid));
  task automatic chk_w(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_f(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic hold_reset;
    @(negedge clk_i);
    rst_i = 1'h1;
    run <= 1'h0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'h0;
    chk_w(word_o, 10'h200);
    chk_f(ladder_sel_o === 32'h0 && !range_o && !word_valid_o && !busy_o, 1'h1);
    $display("reset test done");
  endtask
  // rise m samples row m; the capture at rise m shows row m-3, before that the idle word
  task automatic run_rows;
    coarse_i = rows[0].c;
    over_i = rows[0].o;
    run <= 1'h1;
    for (int m = 0; m < 11; m++) begin
      @(posedge strobe);
      #1;
      chk_w(cap_word, m > 2 ? rows[(m+5)%8].w : 10'h200);
      chk_f(cap_range, m > 2 ? rows[(m+5)%8].r : 1'h0);
      chk_f(cap_valid, 1'(m > 2));
      @(negedge strobe);
      coarse_i = rows[(m+1)%8].c;
      over_i = rows[(m+1)%8].o;
      fine_i = rows[m%8].f;
    end
    $display("stream test done");
  endtask
  initial begin
    hold_reset();
    run_rows();
    hold_reset();
    run <= 1'h1;
    repeat (4) @(posedge strobe);
    hold_reset();
    run_rows();
    final_report();
  end
  initial begin
    #20000;
    errors++;
    $display("Error %0t: timeout", $time);
    final_report();
  end
endmodule
`default_nettype wire
